// [spw_defines.vh]
// Register map, field positions and reset values of the serial port block
`ifndef SPW_DEFINES_VH
`define SPW_DEFINES_VH
`define SPW_OFS_RCSTA 8'h00
`define SPW_OFS_RCREG 8'h04
`define SPW_OFS_TXSTA 8'h08
`define SPW_OFS_TXREG 8'h0C
`define SPW_OFS_BAUD 8'h10
`define SPW_OFS_BRGH 8'h14
`define SPW_OFS_BRGL 8'h18
`define SPW_RC_SERIAL_PORT_ENABLE 7
`define SPW_RC_RX9 6
`define SPW_RC_SREN 5
`define SPW_RC_CREN 4
`define SPW_RC_ADDEN 3
`define SPW_RC_RX9D 0
`define SPW_TX_CLOCK_SOURCE_MASTER 7
`define SPW_TX_TX9 6
`define SPW_TX_TRANSMIT_ENABLE_BIT 5
`define SPW_TX_SYNC 4
`define SPW_TX_SEND_BREAK_REQUEST 3
`define SPW_TX_BRGH 2
`define SPW_TX_SHIFT_REGISTER_EMPTY 1
`define SPW_TX_TRANSMIT_NINTH_BIT 0
`define SPW_BD_RECEIVE_IDLE_STATUS 6
`define SPW_BD_CLOCK_IDLE_POLARITY 4
`define SPW_BD_SIXTEEN_BIT_BAUD_SELECT 3
`define SPW_BD_WUE 1
`define SPW_BD_ABDEN 0
`define SPW_RST_RCSTA 8'h00
`define SPW_RST_TXSTA 8'h02
`define SPW_RST_BAUD 8'h40
`define SPW_RST_BYTE 8'h00
`define SPW_CLK_NS 100
`define SPW_TCY_NS 100
`define SPW_LOAD_CYC ((`SPW_TCY_NS + `SPW_CLK_NS - 1) / `SPW_CLK_NS)
`define SPW_BRK_ZEROS 12
`define SPW_BRK_BITS 4'd14
`endif

// [spw_top.v]
// Serial port: wake on edge, break send, synchronous master transmit, APB registers
`timescale 1ns/100ps
`include "spw_defines.vh"
module spw_top (
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire rx_i,
	output wire rx_o,
	output wire rx_oe,
	output wire tx_o,
	output wire tx_oe,
	input wire rx_byte_valid,
	input wire [8:0] rx_byte,
	input wire rx_busy,
	output wire rx_suspend,
	output wire receive_irq_flag,
	output wire transmit_buffer_empty_flag,
	output wire baud_tick
);
	localparam ST_IDLE = 3'b001;
	localparam ST_LOAD = 3'b010;
	localparam ST_SHIFT = 3'b100;

	function hit;
		input [31:0] a;
		input [7:0] ofs;
		begin
			hit = (a[31:8] == 24'h000000) && (a[7:0] == ofs);
		end
	endfunction

	wire setup_ph = psel & ~penable;
	wire acc_ph = psel & penable;
	wire wr = acc_ph & pwrite;
	wire rd = acc_ph & ~pwrite;
	// Register select lines, one per mapped register in map order
	function [7:0] reg_ofs;
		input integer i;
		begin
			case (i)
				0: reg_ofs = `SPW_OFS_RCSTA;
				1: reg_ofs = `SPW_OFS_RCREG;
				2: reg_ofs = `SPW_OFS_TXSTA;
				3: reg_ofs = `SPW_OFS_TXREG;
				4: reg_ofs = `SPW_OFS_BAUD;
				5: reg_ofs = `SPW_OFS_BRGH;
				default: reg_ofs = `SPW_OFS_BRGL;
			endcase
		end
	endfunction
	wire [6:0] sel;
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1)
		begin : g_sel
			assign sel[gi] = hit(paddr, reg_ofs(gi));
		end
	endgenerate
	wire mapped = |sel;
	wire wr_rcsta = wr & sel[0];
	wire wr_txsta = wr & sel[2];
	wire wr_txreg = wr & sel[3];
	wire wr_baud = wr & sel[4];
	wire wr_brgh = wr & sel[5];
	wire wr_brgl = wr & sel[6];
	wire rd_rcreg = rd & sel[1];

	reg [7:0] rcsta_q;
	reg [7:0] txsta_q;
	reg [7:0] baud_q;
	reg [7:0] brgh_q;
	reg [7:0] brgl_q;
	reg [7:0] txbuf_q;
	reg [8:0] rcreg_q;
	reg txfull_q;
	reg rcif_q;
	reg woke_q;
	reg [31:0] prdata_q;
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [13:0] sh_q;
	reg [3:0] cnt_q;
	reg brk_q;
	reg ph_q;
	reg txd_q;
	reg [15:0] bcnt_q;
	reg rx_m_q;
	reg rx_s_q;
	reg rx_p_q;

	wire serial_port_enable = rcsta_q[`SPW_RC_SERIAL_PORT_ENABLE];
	wire sren = rcsta_q[`SPW_RC_SREN];
	wire cren = rcsta_q[`SPW_RC_CREN];
	wire clock_source_master = txsta_q[`SPW_TX_CLOCK_SOURCE_MASTER];
	wire tx9 = txsta_q[`SPW_TX_TX9];
	wire transmit_enable_bit = txsta_q[`SPW_TX_TRANSMIT_ENABLE_BIT];
	wire syn = txsta_q[`SPW_TX_SYNC];
	wire send_break_request = txsta_q[`SPW_TX_SEND_BREAK_REQUEST];
	wire transmit_ninth_bit = txsta_q[`SPW_TX_TRANSMIT_NINTH_BIT];
	wire clock_idle_polarity = baud_q[`SPW_BD_CLOCK_IDLE_POLARITY];
	wire sixteen_bit_baud_select = baud_q[`SPW_BD_SIXTEEN_BIT_BAUD_SELECT];
	wire wake_on_edge_enable = baud_q[`SPW_BD_WUE];
	wire master = clock_source_master & syn & serial_port_enable;
	wire sync_rx = syn & (sren | cren);
	wire busy = ~st_q[0];
	wire shift_register_empty = ~busy;

	// Two-stage synchroniser; the second stage and its delayed copy rx_p_q feed the edge detect
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
			rx_p_q <= 1'b1;
		end
		else
		begin
			rx_m_q <= rx_i;
			rx_s_q <= rx_m_q;
			rx_p_q <= rx_s_q;
		end
	end
	wire rx_fall = rx_p_q & ~rx_s_q;
	wire rx_rise = ~rx_p_q & rx_s_q;
	wire wake_ev = wake_on_edge_enable & ~woke_q & rx_fall;
	wire wake_end = wake_on_edge_enable & woke_q & rx_rise;

	// Baud generator; restarts at each load so the start bit is a full bit time
	wire [15:0] div = sixteen_bit_baud_select ? {brgh_q, brgl_q} : {8'h00, brgl_q};
	wire tick = serial_port_enable & (bcnt_q == 16'h0000);
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			bcnt_q <= 16'h0000;
		else if (~serial_port_enable || tick || st_q[1])
			bcnt_q <= div;
		else
			bcnt_q <= bcnt_q - 16'h0001;
	end

	// Load waits for an empty shift register; in sync mode a receive blocks it
	wire can_load = txfull_q & transmit_enable_bit & serial_port_enable & ~(syn & sync_rx);
	wire last = (cnt_q == 4'd1);
	wire bit_end = tick & (~syn | ph_q);
	wire done = st_q[2] & bit_end & last;

	always @*
	begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:
				if (can_load)
					st_d = ST_LOAD;
			ST_LOAD:
				st_d = ST_SHIFT;
			ST_SHIFT:
				if (done)
					st_d = can_load ? ST_LOAD : ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// Frame images, shifted out LSB first
	wire [13:0] img_brk = {1'b1, {`SPW_BRK_ZEROS{1'b0}}, 1'b0};
	wire [13:0] img_async = tx9 ? {4'b1111, transmit_ninth_bit, txbuf_q, 1'b0} :
		{4'b1111, 1'b1, txbuf_q, 1'b0};
	wire [13:0] img_sync = {5'b11111, tx9 ? transmit_ninth_bit : 1'b1, txbuf_q};
	wire brk_go = send_break_request & ~syn;
	wire [3:0] n_async = tx9 ? 4'd11 : 4'd10;
	wire [3:0] n_sync = tx9 ? 4'd9 : 4'd8;

	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= ST_IDLE;
			sh_q <= 14'h3FFF;
			cnt_q <= 4'd0;
			brk_q <= 1'b0;
			ph_q <= 1'b0;
			txd_q <= 1'b1;
		end
		else
		begin
			st_q <= st_d;
			if (st_q[1])
			begin
				ph_q <= 1'b0;
				brk_q <= brk_go;
				if (syn)
				begin
					sh_q <= img_sync;
					cnt_q <= n_sync;
				end
				else if (brk_go)
				begin
					sh_q <= img_brk;
					cnt_q <= `SPW_BRK_BITS;
				end
				else
				begin
					sh_q <= img_async;
					cnt_q <= n_async;
				end
			end
			else if (st_q[2] && tick)
			begin
				if (syn)
					ph_q <= ~ph_q;
				if (bit_end)
				begin
					sh_q <= {1'b1, sh_q[13:1]};
					cnt_q <= cnt_q - 4'd1;
				end
			end
			if (st_q[2])
				txd_q <= sh_q[0];
			else
				txd_q <= 1'b1;
		end
	end

	// Buffer flag: a write in the load cycle keeps the new byte pending
	wire load = st_q[1];
	wire brk_clr = done & brk_q;
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			txfull_q <= 1'b0;
			txbuf_q <= `SPW_RST_BYTE;
		end
		else
		begin
			txfull_q <= (txfull_q & ~load) | wr_txreg;
			if (wr_txreg)
				txbuf_q <= pwdata[7:0];
		end
	end

	// Wake tracking and the receive flag; set wins over the read clear
	wire rc_set = wake_ev | (rx_byte_valid & ~wake_on_edge_enable);
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			woke_q <= 1'b0;
			rcif_q <= 1'b0;
			rcreg_q <= 9'h000;
		end
		else
		begin
			if (wake_ev)
				woke_q <= 1'b1;
			else if (wake_end || !wake_on_edge_enable)
				woke_q <= 1'b0;
			rcif_q <= rc_set | (rcif_q & ~rd_rcreg);
			if (rx_byte_valid && !wake_on_edge_enable)
				rcreg_q <= rx_byte;
		end
	end

	// Control registers; hardware clears lose to a software set
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rcsta_q <= `SPW_RST_RCSTA;
			txsta_q <= `SPW_RST_TXSTA;
			baud_q <= `SPW_RST_BAUD;
			brgh_q <= `SPW_RST_BYTE;
			brgl_q <= `SPW_RST_BYTE;
		end
		else
		begin
			if (wr_rcsta)
				rcsta_q <= {pwdata[7:3], 3'b000};
			if (wr_txsta)
				txsta_q <= {pwdata[7:2], 1'b0, pwdata[0]};
			else if (brk_clr)
				txsta_q[`SPW_TX_SEND_BREAK_REQUEST] <= 1'b0;
			if (wr_baud)
				baud_q <= {1'b0, 1'b0, 1'b0, pwdata[4:3], 1'b0, pwdata[1:0]};
			else if (wake_end)
				baud_q[`SPW_BD_WUE] <= 1'b0;
			if (wr_brgh)
				brgh_q <= pwdata[7:0];
			if (wr_brgl)
				brgl_q <= pwdata[7:0];
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop
	reg [7:0] rmux;
	always @*
	begin
		rmux = 8'h00;
		if (hit(paddr, `SPW_OFS_RCSTA))
			rmux = {rcsta_q[7:1], rcreg_q[8]};
		else if (hit(paddr, `SPW_OFS_RCREG))
			rmux = rcreg_q[7:0];
		else if (hit(paddr, `SPW_OFS_TXSTA))
			rmux = {txsta_q[7:2], shift_register_empty, txsta_q[0]};
		else if (hit(paddr, `SPW_OFS_TXREG))
			rmux = txbuf_q;
		else if (hit(paddr, `SPW_OFS_BAUD))
			rmux = {1'b0, ~rx_busy, baud_q[5:0]};
		else if (hit(paddr, `SPW_OFS_BRGH))
			rmux = brgh_q;
		else if (hit(paddr, `SPW_OFS_BRGL))
			rmux = brgl_q;
	end
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			prdata_q <= 32'h00000000;
		else if (setup_ph)
			prdata_q <= {24'h000000, rmux};
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = acc_ph & ~mapped;

	// Receiver is held off while waking or while a sync word goes out
	assign rx_suspend = wake_on_edge_enable | (syn & busy);
	wire ck_line = clock_idle_polarity ^ ph_q;
	assign tx_oe = serial_port_enable & (~syn | clock_source_master);
	// tx_o and rx_o come from flops; data is delayed with the clock so their spacing holds
	reg line_q;
	reg dt_q;
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			line_q <= 1'b1;
			dt_q <= 1'b1;
		end
		else
		begin
			line_q <= syn ? ck_line : txd_q;
			dt_q <= txd_q;
		end
	end
	assign tx_o = line_q;
	assign rx_oe = master & busy & ~sync_rx;
	assign rx_o = dt_q;
	assign receive_irq_flag = rcif_q;
	assign transmit_buffer_empty_flag = ~txfull_q;
	assign baud_tick = tick;
endmodule // spw_top

// [spw_chk_properties.sv]
// Port assertions for the serial port block
`timescale 1ns/100ps
module spw_chk (
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire rx_i,
	input wire rx_oe,
	input wire tx_oe,
	input wire rx_byte_valid,
	input wire rx_suspend,
	input wire receive_irq_flag,
	input wire transmit_buffer_empty_flag
);
	wire acc = psel && penable;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	err_map_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("odd address accepted");
	err_read_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read not zero");
	high_zero_a: assert property (acc |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	txf_fall_a: assert property ($fell(transmit_buffer_empty_flag) |->
		$past(acc && pwrite && paddr == 32'h0C)) else $error("empty flag cleared alone");
	rxf_fall_a: assert property ($fell(receive_irq_flag) |->
		$past(acc && !pwrite && paddr == 32'h04)) else $error("rx flag cleared alone");
	half_dup_a: assert property (rx_oe |-> rx_suspend)
		else $error("receive open while sending");
	master_clk_a: assert property (rx_oe |-> tx_oe)
		else $error("data driven without clock");
	wake_flag_a: assert property ($fell(rx_i) && rx_suspend && !rx_oe |->
		##[1:6] receive_irq_flag) else $error("wake edge missed");
	byte_flag_a: assert property (rx_byte_valid && !rx_suspend |=> receive_irq_flag)
		else $error("byte not flagged");
	cover property ($fell(receive_irq_flag));
	cover property ($rose(rx_oe));
	cover property ($rose(transmit_buffer_empty_flag));
endmodule // spw_chk
bind spw_top spw_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .rx_i(rx_i),
	.rx_oe(rx_oe), .tx_oe(tx_oe), .rx_byte_valid(rx_byte_valid), .rx_suspend(rx_suspend),
	.receive_irq_flag(receive_irq_flag),
	.transmit_buffer_empty_flag(transmit_buffer_empty_flag));

// [spw_node.sv]
// Remote serial node and receiver stand-in
`timescale 1ns/100ps
module spw_node (
	input wire mclk,
	input wire rx_o,
	input wire rx_oe,
	output wire rx_i,
	output logic rx_busy,
	output logic rx_byte_valid,
	output logic [8:0] rx_byte
);
	logic line_q = 1'b1;
	// Node's line_q drives the pin when released; high except while zeros runs
	assign rx_i = rx_oe ? rx_o : line_q;
	initial
	begin
		rx_busy = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 9'h0;
	end
	// All-zero character, no early rising edge
	task automatic zeros(input int bits);
	begin
		line_q <= 1'b0;
		repeat (bits * 8) @(posedge mclk);
		line_q <= 1'b1;
	end
	endtask
	task automatic deliver(input logic [8:0] b);
	begin
		rx_busy <= 1'b1;
		repeat (4) @(posedge mclk);
		rx_busy <= 1'b0;
		rx_byte <= b;
		rx_byte_valid <= 1'b1;
		@(posedge mclk);
		rx_byte_valid <= 1'b0;
	end
	endtask
endmodule // spw_node

// [tb_top.sv]
// Self-checking bench for the serial port block
`timescale 1ns/100ps
module tb_top;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, seed = 32'h1FAF;
	logic perr;
	logic [8:0] b;
	int error_cnt = 0, num_checks = 0, cyc = 0;
	logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
	logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h02, 8'h40, 8'h00, 8'h00, 8'h00};
	wire [31:0] prdata;
	wire [8:0] rx_byte;
	wire pready, pslverr, rx_i, rx_o, rx_oe, tx_o, tx_oe, rx_byte_valid, rx_busy, rx_suspend;
	wire rif, tif;
	spw_top DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_i(rx_i), .rx_o(rx_o), .rx_oe(rx_oe), .tx_o(tx_o), .tx_oe(tx_oe),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_busy(rx_busy),
		.rx_suspend(rx_suspend), .receive_irq_flag(rif), .transmit_buffer_empty_flag(tif),
		.baud_tick());
	spw_node node (.mclk(mclk), .rx_o(rx_o), .rx_oe(rx_oe), .rx_i(rx_i), .rx_busy(rx_busy),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));
	initial
		forever #50 mclk = ~mclk;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Expected line level of bit i in an async or break frame
	function automatic logic fbit(input logic [7:0] d, input logic brk, input int i);
		if (brk)
			return i == 13;
		return i == 0 ? 1'b0 : (i == 9 ? 1'b1 : d[i - 1]);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
	begin
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	end
	endtask
	task automatic wait_tx(input logic v);
		while (tx_o !== v) @(posedge mclk);
	endtask
	// Samples near the middle of each 8-cycle bit
	task automatic frame(input logic [7:0] d, input logic brk);
		wait_tx(1'b0);
		for (int i = 0; i < (brk ? 14 : 10); i++)
		begin
			repeat (i ? 8 : 3) @(posedge mclk);
			chk(tx_o, fbit(d, brk, i));
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			error_cnt++;
			conclude();
		end
	end
	initial
	begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		foreach (ofs[i])
		begin
			apb(1'b0, ofs[i], 8'h0);
			chk(rd, rst[i]);
			chk(perr, ofs[i] == 8'h1C);
		end
		apb(1'b0, 8'h05, 8'h0);
		chk(perr, 1'b1);
		seed = nxt(seed);
		apb(1'b1, 8'h14, seed[7:0]);
		apb(1'b0, 8'h14, 8'h0);
		chk(rd, seed[7:0]);
		apb(1'b1, 8'h18, 8'h07);
		apb(1'b1, 8'h00, 8'h80);
		apb(1'b1, 8'h08, 8'h20);
		apb(1'b1, 8'h0C, seed[15:8]);
		frame(seed[15:8], 1'b0);
		chk(tif, 1'b1);
		apb(1'b1, 8'h08, 8'h28);
		apb(1'b1, 8'h0C, 8'hFF);
		fork
			frame(8'h0, 1'b1);
			begin
				repeat (3) @(posedge mclk);
				apb(1'b0, 8'h08, 8'h0);
				chk(rd, 8'h28);
				apb(1'b1, 8'h0C, 8'h55);
			end
		join
		frame(8'h55, 1'b0);
		repeat (8) @(posedge mclk);
		apb(1'b0, 8'h08, 8'h0);
		chk(rd, 8'h22);
		$display("transmit done");
		apb(1'b1, 8'h00, 8'h90);
		apb(1'b0, 8'h10, 8'h0);
		chk(rd, 8'h40);
		apb(1'b1, 8'h10, 8'h02);
		node.zeros(12);
		chk(rif, 1'b1);
		repeat (6) @(posedge mclk);
		apb(1'b0, 8'h10, 8'h0);
		chk(rd, 8'h40);
		apb(1'b0, 8'h04, 8'h0);
		@(posedge mclk);
		chk(rif, 1'b0);
		node.deliver({1'b0, seed[23:16]});
		@(posedge mclk);
		chk(rif, 1'b1);
		apb(1'b0, 8'h04, 8'h0);
		chk(rd, seed[23:16]);
		$display("wake done");
		b = {1'b1, seed[31:24]};
		apb(1'b1, 8'h18, 8'h0C);
		apb(1'b0, 8'h18, 8'h0);
		chk(rd, 8'h0C);
		apb(1'b1, 8'h00, 8'h80);
		apb(1'b1, 8'h10, 8'h10);
		apb(1'b1, 8'h08, 8'hF1);
		@(posedge mclk);
		chk({tx_oe, tx_o}, 2'h3);
		apb(1'b1, 8'h0C, b[7:0]);
		for (int i = 0; i < 9; i++)
		begin
			wait_tx(1'b0);
			chk({rx_oe, rx_suspend, rx_o}, {2'h3, b[i]});
			wait_tx(1'b1);
		end
		$display("sync done");
		conclude();
	end
endmodule // tb_top
